// >>> vic_map.svh
// Register offsets, write masks, reset values and timing counts
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH
`define VIC_OFF_INPUT 8'h00
`define VIC_OFF_VSEL 8'h01
`define VIC_OFF_ENH 8'h02
`define VIC_OFF_STAT 8'h03
`define VIC_RST_INPUT 8'h00
`define VIC_RST_VSEL 8'h00
`define VIC_RST_ENH 8'h04
`define VIC_VSEL_WMASK 8'hbf
`define VIC_ENH_WMASK 8'h1f
`define VIC_REACQ_NS 1000
`define VIC_CLK_MHZ 200
`define VIC_REACQ_CYC ((`VIC_REACQ_NS * `VIC_CLK_MHZ) / 1000)
`endif

// >>> vic_pkg.sv
// Types shared by the video input configuration block
package vic_pkg;
  typedef enum logic [1:0] {VIC_FMT_CVBS, VIC_FMT_YC, VIC_FMT_YUV,
    VIC_FMT_NONE} vic_fmt_e;
  typedef enum logic [2:0] {VIC_STD_AUTO_PAL_NTSC, VIC_STD_NTSC_M,
    VIC_STD_NTSC_443, VIC_STD_PAL_BGHID, VIC_STD_PAL_N, VIC_STD_PAL_M,
    VIC_STD_PAL_CN, VIC_STD_NONE} vic_std_e;
  typedef struct packed {
    vic_fmt_e fmt;
    logic [5:0] luma_sel;
    logic [5:0] chroma_sel;
    logic [5:0] v_sel;
    logic differential;
  } vic_route_s;
  typedef struct packed {
    vic_std_e std;
    logic auto_detect;
    logic auto_pal_n;
    logic pedestal;
    logic [1:0] signal_quality_setting;
    logic square_pixel_enable;
    logic four_subcarrier_sampling;
    logic line_clk_4fsc;
    logic alt_component_input;
  } vic_video_s;
  typedef struct packed {
    logic [2:0] luma_peaking_mode;
    logic peak_boost;
    logic peak_cut;
    logic [1:0] low_level_truncation;
    logic [5:0] coring_threshold;
  } vic_enh_s;
endpackage

// >>> vic_regs.sv
// Input, video selection and enhancement registers on classic Wishbone
// Function
// R1 - Codes 0-5 pick composite on inputs 1-6
// R2 - Codes 6-8 pick luma/chroma input pairs
// R3 - Codes 9-10 pick component input triples
// R4 - Software avoids unlisted source and standard codes
// R5 - Standard codes 0-3 auto-detect, bit0 pedestal
// R6 - Standard codes 4-13 force fixed standard
// R7 - Quality bits 1:0 set time constant
// R8 - Bit 2 enables square-pixel sampling
// R9 - Bit 3 makes all inputs differential
// R10 - Bit 4 resamples at four times subcarrier
// R11 - Software uses 4Fsc only with NTSC
// R12 - Source change reacquires unless bit 7 set
// R13 - Reacquire mode relocks to new input
// R14 - Peaking bits 2:0, code 4 is unity
// R15 - Coring bits 4:3 truncate below black+8/16/32
// R16 - Software writes reserved bits as zero
// R17 - Input and standard fields at subaddress 00
// R18 - Peaking acts near colour subcarrier frequency
`timescale 1ns/1ps
`include "vic_map.svh"
module vic_regs import vic_pkg::*; #(
  parameter int REACQ_CYCLES = `VIC_REACQ_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Decoded controls
  output vic_route_s route_o,
  output vic_video_s video_o,
  output vic_enh_s enh_o,
  output logic reacquire_o,
  // Lock indication from the front end
  input wire logic lock_i
);
  // Counter is 16 bits wide; longer waits need a wider count
  if (REACQ_CYCLES < 1 || REACQ_CYCLES > 65535) begin : g_bad_reacq
    $error("REACQ_CYCLES out of range");
  end

  typedef enum {ST_RUN, ST_REACQ} vic_state_e;

  // Input source decode, used for routing and validity
  function automatic vic_route_s decode_src(input logic [3:0] c,
                                            input logic diff);
    vic_route_s r;
    r = '0;
    r.differential = diff;
    // R1 composite channel
    if (c <= 4'h5) begin
      r.fmt = VIC_FMT_CVBS;
      r.luma_sel = 6'h01 << c[2:0];
    end else if (c <= 4'h8) begin
      // R2 luma/chroma pair
      r.fmt = VIC_FMT_YC;
      // Low bits wrap, so code 8 selects the third pair
      r.luma_sel = 6'h01 << (c[2:0] - 3'h6);
      r.chroma_sel = 6'h08 << (c[2:0] - 3'h6);
    end else if (c == 4'h9) begin
      // R3 component, first triple
      r.fmt = VIC_FMT_YUV;
      r.luma_sel = 6'h01;
      r.chroma_sel = 6'h08;
      r.v_sel = 6'h10;
    end else if (c == 4'ha) begin
      r.fmt = VIC_FMT_YUV;
      r.luma_sel = 6'h02;
      r.chroma_sel = 6'h04;
      r.v_sel = 6'h20;
    end else begin
      // R4 unlisted codes route nothing
      r.fmt = VIC_FMT_NONE;
    end
    return r;
  endfunction

  logic [7:0] input_q, input_d, vsel_q, vsel_d, enh_q, enh_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic err_q, err_d;
  vic_state_e state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic chg_q, chg_d;
  logic req, wr;
  logic [7:0] wmask;

  assign req = cyc_i && stb_i && !ack_q && !err_q;
  assign wr = req && we_i && sel_i[0];
  assign wmask = 8'hff;

  // Bus slave and register writes; one-cycle answer
  always_comb begin
    input_d = input_q;
    vsel_d = vsel_q;
    enh_d = enh_q;
    ack_d = 1'b0;
    err_d = 1'b0;
    dat_d = dat_q;
    if (req) begin
      unique case (adr_i)
        // R17 input and standard at subaddress 00
        `VIC_OFF_INPUT: begin
          ack_d = 1'b1;
          dat_d = {24'h0, input_q};
          if (wr)
            input_d = dat_i[7:0] & wmask;
        end
        // R16 reserved bits held at zero
        `VIC_OFF_VSEL: begin
          ack_d = 1'b1;
          dat_d = {24'h0, vsel_q};
          if (wr)
            vsel_d = dat_i[7:0] & `VIC_VSEL_WMASK;
        end
        `VIC_OFF_ENH: begin
          ack_d = 1'b1;
          dat_d = {24'h0, enh_q};
          if (wr)
            enh_d = dat_i[7:0] & `VIC_ENH_WMASK;
        end
        `VIC_OFF_STAT: begin
          ack_d = 1'b1;
          dat_d = {29'h0, lock_i, chg_q, state_q == ST_REACQ};
        end
        default: begin
          err_d = 1'b1;
          dat_d = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_q <= `VIC_RST_INPUT;
      vsel_q <= `VIC_RST_VSEL;
      enh_q <= `VIC_RST_ENH;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      input_q <= input_d;
      vsel_q <= vsel_d;
      enh_q <= enh_d;
      ack_q <= ack_d;
      err_q <= err_d;
      dat_q <= dat_d;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = dat_q;

  // Reacquire sequencer; a source change restarts the wait
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    chg_d = 1'b0;
    // R12 source change unless auto-start bit set
    if (wr && adr_i == `VIC_OFF_INPUT && !vsel_q[7] &&
        dat_i[3:0] != input_q[3:0])
      chg_d = 1'b1;
    unique case (state_q)
      ST_RUN: begin
        if (chg_q) begin
          state_d = ST_REACQ;
          cnt_d = 16'(REACQ_CYCLES - 1);
        end
      end
      // R13 hold reacquire until relock time expires
      ST_REACQ: begin
        if (chg_q)
          cnt_d = 16'(REACQ_CYCLES - 1);
        else if (cnt_q != 16'h0)
          cnt_d = cnt_q - 16'h1;
        else
          state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      cnt_q <= 16'h0;
      chg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      chg_q <= chg_d;
    end
  end

  assign reacquire_o = state_q == ST_REACQ;

  // Decoded controls from stored fields
  always_comb begin
    // R9 differential applies to every source
    route_o = decode_src(input_q[3:0], vsel_q[3]);
    video_o = '0;
    // R5 auto-detect codes, bit0 pedestal
    video_o.pedestal = input_q[4];
    video_o.auto_detect = input_q[7:4] <= 4'h3;
    video_o.auto_pal_n = input_q[7:4] <= 4'h3 && input_q[5];
    // R6 forced standards
    unique case (input_q[7:4])
      4'h0, 4'h1, 4'h2, 4'h3: video_o.std = VIC_STD_AUTO_PAL_NTSC;
      4'h4, 4'h5: video_o.std = VIC_STD_NTSC_M;
      4'h6, 4'h7: video_o.std = VIC_STD_NTSC_443;
      4'h8: video_o.std = VIC_STD_PAL_BGHID;
      4'h9: video_o.std = VIC_STD_PAL_N;
      4'ha, 4'hb: video_o.std = VIC_STD_PAL_M;
      4'hc, 4'hd: video_o.std = VIC_STD_PAL_CN;
      default: video_o.std = VIC_STD_NONE;
    endcase
    // R7 time constant grade
    video_o.signal_quality_setting = vsel_q[1:0];
    // R8 square pixel
    video_o.square_pixel_enable = vsel_q[2];
    // R10 pixel clock follows 4Fsc resampling
    video_o.four_subcarrier_sampling = vsel_q[4];
    video_o.line_clk_4fsc = vsel_q[4];
    video_o.alt_component_input = vsel_q[5];
    enh_o = '0;
    // R14 R18 peaking gain around subcarrier
    enh_o.luma_peaking_mode = enh_q[2:0];
    enh_o.peak_boost = enh_q[2:0] < 3'h4;
    enh_o.peak_cut = enh_q[2:0] > 3'h4;
    // R15 coring threshold above black
    enh_o.low_level_truncation = enh_q[4:3];
    unique case (enh_q[4:3])
      2'h0: enh_o.coring_threshold = 6'h00;
      2'h1: enh_o.coring_threshold = 6'h08;
      2'h2: enh_o.coring_threshold = 6'h10;
      2'h3: enh_o.coring_threshold = 6'h20;
    endcase
  end

  // Checks
  a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  a_write_lands: assert property (@(posedge core_clk) disable iff (rst) // R17
    wr && adr_i == `VIC_OFF_INPUT |=> input_q == $past(dat_i[7:0]))
    else $error("input register write lost");
  a_reserved_zero: assert property (@(posedge core_clk) // R16
    disable iff (rst) !vsel_q[6] && enh_q[7:5] == 3'h0)
    else $error("reserved bit set");
  a_reacq_start: assert property (@(posedge core_clk) disable iff (rst) // R12
    wr && adr_i == `VIC_OFF_INPUT && !vsel_q[7] &&
    dat_i[3:0] != input_q[3:0] |=> ##1 reacquire_o)
    else $error("no reacquire after source change");
  a_no_reacq: assert property (@(posedge core_clk) disable iff (rst) // R12
    !reacquire_o && !chg_q && !(wr && adr_i == `VIC_OFF_INPUT)
    |=> !chg_q) else $error("spurious reacquire");
  a_reacq_ends: assert property (@(posedge core_clk) disable iff (rst) // R13
    reacquire_o && cnt_q == 16'h0 && !chg_q |=> !reacquire_o)
    else $error("reacquire not ended");
  a_cvbs_route: assert property (@(posedge core_clk) disable iff (rst) // R1
    input_q[3:0] == 4'h2 |-> route_o.fmt == VIC_FMT_CVBS &&
    route_o.luma_sel == 6'h04) else $error("composite route wrong");
  a_yc_route: assert property (@(posedge core_clk) disable iff (rst) // R2
    input_q[3:0] == 4'h8 |-> route_o.luma_sel == 6'h04 &&
    route_o.chroma_sel == 6'h20) else $error("luma/chroma route wrong");
  a_yuv_route: assert property (@(posedge core_clk) disable iff (rst) // R3
    input_q[3:0] == 4'ha |-> route_o.v_sel == 6'h20)
    else $error("component route wrong");
  a_peak_unity: assert property (@(posedge core_clk) disable iff (rst) // R14
    enh_q[2:0] == 3'h4 |-> !enh_o.peak_boost && !enh_o.peak_cut)
    else $error("unity peaking wrong");
  a_core_level: assert property (@(posedge core_clk) disable iff (rst) // R15
    enh_q[4:3] == 2'h3 |-> enh_o.coring_threshold == 6'h20)
    else $error("coring threshold wrong");
  a_diff_route: assert property (@(posedge core_clk) disable iff (rst) // R9
    vsel_q[3] |-> route_o.differential)
    else $error("differential flag lost");
  a_fsc_clock: assert property (@(posedge core_clk) disable iff (rst) // R10
    vsel_q[4] |-> video_o.line_clk_4fsc && video_o.four_subcarrier_sampling)
    else $error("pixel clock not at four times subcarrier");
  a_reacq_restart: assert property (@(posedge core_clk) disable iff (rst) // R13
    reacquire_o && chg_q |=> reacquire_o && cnt_q == 16'(REACQ_CYCLES - 1))
    else $error("reacquire wait not restarted");
  a_auto_std: assert property (@(posedge core_clk) disable iff (rst) // R5
    input_q[7:4] == 4'h1 |-> video_o.auto_detect && video_o.pedestal)
    else $error("auto-detect decode wrong");
  a_forced_std: assert property (@(posedge core_clk) disable iff (rst) // R6
    input_q[7:4] == 4'h9 |->
    video_o.std == VIC_STD_PAL_N && video_o.pedestal)
    else $error("forced standard wrong");
  c_write_input: cover property (@(posedge core_clk) disable iff (rst)
    wr && adr_i == `VIC_OFF_INPUT);
  c_reacquire: cover property (@(posedge core_clk) disable iff (rst)
    $rose(reacquire_o));
  c_unmapped: cover property (@(posedge core_clk) disable iff (rst) err_o);
  c_restart: cover property (@(posedge core_clk) disable iff (rst)
    reacquire_o && chg_q);
  c_four_fsc: cover property (@(posedge core_clk) disable iff (rst)
    video_o.four_subcarrier_sampling);
endmodule

// >>> video_input_config_regs_bench.sv
// Self-checking bench for the video input configuration registers
`timescale 1ns/1ps
`include "vic_map.svh"
module video_input_config_regs_bench import vic_pkg::*;;
  // Short reacquire count keeps the run brief
  localparam int REACQ = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic lock_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, err_o, reacquire_o;
  vic_route_s route_o;
  vic_video_s video_o;
  vic_enh_s enh_o;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int checks_done = 0;
  vic_std_e stds [15] = '{VIC_STD_AUTO_PAL_NTSC, VIC_STD_AUTO_PAL_NTSC,
    VIC_STD_AUTO_PAL_NTSC, VIC_STD_AUTO_PAL_NTSC, VIC_STD_NTSC_M,
    VIC_STD_NTSC_M, VIC_STD_NTSC_443, VIC_STD_NTSC_443, VIC_STD_PAL_BGHID,
    VIC_STD_PAL_N, VIC_STD_PAL_M, VIC_STD_PAL_M, VIC_STD_PAL_CN,
    VIC_STD_PAL_CN, VIC_STD_NONE};
  logic [5:0] thr [4] = '{6'h00, 6'h08, 6'h10, 6'h20};

  vic_regs #(.REACQ_CYCLES(REACQ)) i_dut (.core_clk(core_clk), .rst(rst),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .route_o(route_o), .video_o(video_o), .enh_o(enh_o),
    .reacquire_o(reacquire_o), .lock_i(lock_i));

  // Free-running 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle; waits for ack or err, never a fixed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = dat_o;
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
    @(negedge core_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 4'h1);
    chk(rd, {24'h0, e});
  endtask

  // Expected routing for one source code
  function automatic vic_route_s exp_route(input int c, input logic df);
    vic_route_s r;
    r = '0;
    r.differential = df;
    if (c < 6) begin
      r.luma_sel = 6'h01 << c;
    end else if (c < 9) begin
      r.fmt = VIC_FMT_YC;
      r.luma_sel = 6'h01 << (c - 6);
      r.chroma_sel = 6'h01 << (c - 3);
    end else if (c < 11) begin
      r.fmt = VIC_FMT_YUV;
      r.luma_sel = (c == 9) ? 6'h01 : 6'h02;
      r.chroma_sel = (c == 9) ? 6'h08 : 6'h04;
      r.v_sel = (c == 9) ? 6'h10 : 6'h20;
    end else begin
      r.fmt = VIC_FMT_NONE;
    end
    return r;
  endfunction

  task automatic t_reset();
    rdchk(`VIC_OFF_INPUT, `VIC_RST_INPUT);
    rdchk(`VIC_OFF_VSEL, `VIC_RST_VSEL);
    rdchk(`VIC_OFF_ENH, `VIC_RST_ENH);
  endtask

  // Every listed source code (0-10), single-ended then differential
  task automatic t_route();
    for (int df = 0; df < 2; df++) begin
      wr(`VIC_OFF_VSEL, 8'(df << 3));
      // only listed source codes are driven
      for (int c = 0; c < 11; c++) begin
        wr(`VIC_OFF_INPUT, 8'(c));
        chk(32'(route_o), 32'(exp_route(c, df[0])));
      end
    end
  endtask

  task automatic t_std();
    // only listed standard codes are driven
    for (int c = 0; c < 14; c++) begin
      wr(`VIC_OFF_INPUT, 8'(c << 4));
      chk(32'(video_o.std), 32'(stds[c]));
      chk(32'(video_o.pedestal), 32'(c[0]));
      chk(32'(video_o.auto_detect), 32'(c < 4));
      if (c < 4) chk(32'(video_o.auto_pal_n), 32'(c[1]));
    end
  endtask

  task automatic t_vsel();
    wr(`VIC_OFF_INPUT, 8'h40);
    for (int i = 0; i < 32; i++) begin
      wr(`VIC_OFF_VSEL, 8'(i) | 8'h80);
      chk(32'(video_o.signal_quality_setting), 32'(i[1:0]));
      chk(32'(video_o.square_pixel_enable), 32'(i[2]));
      chk(32'(video_o.four_subcarrier_sampling), 32'(i[4]));
      chk(32'(video_o.line_clk_4fsc), 32'(i[4]));
      rdchk(`VIC_OFF_VSEL, 8'(i) | 8'h80);
    end
    wr(`VIC_OFF_VSEL, `VIC_VSEL_WMASK);
    rdchk(`VIC_OFF_VSEL, `VIC_VSEL_WMASK);
  endtask

  task automatic t_enh();
    for (int i = 0; i < 32; i++) begin
      wr(`VIC_OFF_ENH, 8'(i));
      chk(32'(enh_o.luma_peaking_mode), 32'(i[2:0]));
      chk(32'(enh_o.peak_boost), 32'(i[2:0] < 3'h4));
      chk(32'(enh_o.peak_cut), 32'(i[2:0] > 3'h4));
      chk(32'(enh_o.low_level_truncation), 32'(i[4:3]));
      chk(32'(enh_o.coring_threshold), 32'(thr[i[4:3]]));
      rdchk(`VIC_OFF_ENH, 8'(i));
    end
    wr(`VIC_OFF_ENH, `VIC_ENH_WMASK);
    rdchk(`VIC_OFF_ENH, `VIC_ENH_WMASK);
  endtask

  // Counts reacquire cycles from the ack of a source write
  task automatic reacq_count(input logic [7:0] d, input int e);
    int n;
    n = 0;
    wb(1'b1, `VIC_OFF_INPUT, d, 4'h1);
    repeat (30) begin
      @(negedge core_clk);
      if (reacquire_o === 1'b1) n++;
    end
    chk(32'(n), 32'(e));
  endtask

  task automatic reacq_after(input logic [7:0] v, input logic [7:0] d,
                             input int e);
    wr(`VIC_OFF_VSEL, v);
    repeat (20) @(negedge core_clk);
    reacq_count(d, e);
  endtask

  task automatic t_reacq();
    reacq_after(8'h00, 8'h03, REACQ);
    reacq_after(8'h00, 8'h03, 0);
    reacq_after(8'h00, 8'h53, 0);
    // A second change while reacquiring restarts the wait
    wr(`VIC_OFF_INPUT, 8'h01);
    reacq_count(8'h02, REACQ);
    reacq_after(8'h80, 8'h05, 0);
  endtask

  // Unmapped place, masked lane, read-only status
  task automatic t_bus();
    wb(1'b1, 8'h04, 8'h55, 4'h1);
    chk(32'(er), 32'h1);
    wb(1'b0, 8'h80, 8'h00, 4'h1);
    chk(32'(er), 32'h1);
    wr(`VIC_OFF_ENH, 8'h0a);
    wb(1'b1, `VIC_OFF_ENH, 8'h11, 4'h0);
    rdchk(`VIC_OFF_ENH, 8'h0a);
    @(posedge core_clk);
    lock_i <= 1'b1;
    wr(`VIC_OFF_STAT, 8'hff);
    rdchk(`VIC_OFF_STAT, 8'h04);
  endtask

  // Reset in mid-run returns every register to its reset value
  task automatic t_rerst();
    wr(`VIC_OFF_INPUT, 8'h97);
    wr(`VIC_OFF_ENH, 8'h1b);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    chk(32'(reacquire_o), 32'h0);
    rdchk(`VIC_OFF_INPUT, `VIC_RST_INPUT);
    rdchk(`VIC_OFF_VSEL, `VIC_RST_VSEL);
    rdchk(`VIC_OFF_ENH, `VIC_RST_ENH);
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_std();
    t_vsel();
    t_enh();
    t_reacq();
    t_bus();
    t_rerst();
    conclude();
  end

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule
